// ### pde_pkg.sv
package pde_pkg;

  // ----------------------------------------------------------------
  // link characters
  // ----------------------------------------------------------------
  localparam logic [7:0] BAUD_TRAINING_CHAR = 8'h55;
  localparam logic [7:0] ACK_CHAR = 8'h40;

  // ----------------------------------------------------------------
  // instruction byte layout
  // ----------------------------------------------------------------
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 5;
  localparam int SIZE_A_MSB = 3;
  localparam int SIZE_A_LSB = 2;
  localparam int SIZE_B_MSB = 1;
  localparam int SIZE_B_LSB = 0;
  localparam int CS_ADDR_MSB = 3;
  localparam int CS_ADDR_LSB = 0;

  localparam logic [2:0] OPC_READ_DIRECT = 3'h0;
  localparam logic [2:0] OPC_READ_VIA_POINTER = 3'h1;
  localparam logic [2:0] OPC_WRITE_DIRECT = 3'h2;
  localparam logic [2:0] OPC_WRITE_VIA_POINTER = 3'h3;
  localparam logic [2:0] OPC_READ_CONTROL_REG = 3'h4;
  localparam logic [2:0] OPC_LOOP_COUNT = 3'h5;
  localparam logic [2:0] OPC_WRITE_CONTROL_REG = 3'h6;

  // pointer-select codes
  localparam logic [1:0] PTR_AT = 2'h0;
  localparam logic [1:0] PTR_AT_INC = 2'h1;
  localparam logic [1:0] PTR_REG = 2'h2;

  // address size code 3 is reserved
  localparam logic [1:0] ASIZE_RESERVED = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PTR_RESET = 32'h0;
  localparam logic [7:0] RPT_RESET = 8'h0;

  typedef enum logic [3:0] {
    ST_SYNC,
    ST_INSTR,
    ST_ADDR,
    ST_DATA,
    ST_RPT,
    ST_CSRD,
    ST_BUS,
    ST_GUARD,
    ST_TX,
    ST_ERR
  } pde_state_e;

  typedef struct packed {
    pde_state_e st;
    logic [7:0] op;
    logic [1:0] bi;
    logic [1:0] last;
    logic wr_phase;
    logic turn;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] ptr;
    logic [7:0] rpt;
    logic rpt_pend;
    logic rpt_act;
    logic [15:0] gcyc;
    logic [7:0] gbits;
    logic bus_req;
    logic bus_we;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
    logic [1:0] bus_size;
    logic tx_valid;
    logic [7:0] tx_data;
    logic cs_we;
    logic [3:0] cs_addr;
    logic [7:0] cs_wdata;
    logic err;
  } pde_regs_s;

endpackage

// ### pde_engine.sv
`timescale 1ns/1ps
module pde_engine (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_break_i,
  input wire logic rx_error_i,
  input wire logic [15:0] bit_period_i,
  input wire logic [7:0] guard_bits_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic bus_req_o,
  output logic bus_we_o,
  output logic [31:0] bus_addr_o,
  output logic [31:0] bus_wdata_o,
  output logic [1:0] bus_size_o,
  input wire logic bus_ack_i,
  input wire logic bus_err_i,
  input wire logic [31:0] bus_rdata_i,
  output logic cs_we_o,
  output logic [3:0] cs_addr_o,
  output logic [7:0] cs_wdata_o,
  input wire logic [7:0] cs_rdata_i,
  output logic [31:0] pointer_o,
  output logic error_state_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pde_pkg::pde_regs_s r_ff;
  pde_pkg::pde_regs_s nxt_r;

  logic [2:0] opc;
  logic [1:0] size_a;
  logic [1:0] size_b;
  logic [31:0] inc;

  assign opc = r_ff.op[pde_pkg::OPC_MSB:pde_pkg::OPC_LSB];
  assign size_a = r_ff.op[pde_pkg::SIZE_A_MSB:pde_pkg::SIZE_A_LSB];
  assign size_b = r_ff.op[pde_pkg::SIZE_B_MSB:pde_pkg::SIZE_B_LSB];
  assign inc = {30'h0, size_b} + 32'h1;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic start;
    logic done;
    logic resp;
    logic [2:0] nopc;
    logic [1:0] na;
    logic [1:0] nb;
    start = 1'b0;
    done = 1'b0;
    resp = 1'b0;
    nopc = 3'h0;
    na = 2'h0;
    nb = 2'h0;
    nxt_r = r_ff;
    nxt_r.cs_we = 1'b0;

    // any received byte means the next answer follows a turnaround
    if (rx_valid_i && r_ff.st != pde_pkg::ST_ERR) begin
      nxt_r.turn = 1'b1;
    end

    case (r_ff.st)
      pde_pkg::ST_SYNC: begin
        if (rx_valid_i) begin
          if (rx_data_i == pde_pkg::BAUD_TRAINING_CHAR) begin
            nxt_r.st = pde_pkg::ST_INSTR;
          end else begin
            nxt_r.st = pde_pkg::ST_ERR;
          end
        end
      end
      pde_pkg::ST_INSTR: begin
        if (rx_valid_i) begin
          nxt_r.op = rx_data_i;
          if (r_ff.rpt_pend) begin
            nxt_r.rpt_pend = 1'b0;
            nxt_r.rpt_act = 1'b1;
            if (rx_data_i[pde_pkg::OPC_MSB:pde_pkg::OPC_LSB] == pde_pkg::OPC_LOOP_COUNT) begin
              nxt_r.st = pde_pkg::ST_ERR;
            end else begin
              start = 1'b1;
            end
          end else begin
            start = 1'b1;
          end
        end
      end
      pde_pkg::ST_RPT: begin
        if (rx_valid_i) begin
          // only the low byte counts: at most 255 repeats
          if (r_ff.bi == 2'h0) begin
            nxt_r.rpt = rx_data_i;
          end
          if (r_ff.bi == r_ff.last) begin
            nxt_r.rpt_pend = 1'b1;
            nxt_r.st = pde_pkg::ST_SYNC;
          end else begin
            nxt_r.bi = r_ff.bi + 2'h1;
          end
        end
      end
      pde_pkg::ST_ADDR: begin
        if (rx_valid_i) begin
          nxt_r.addr[{r_ff.bi, 3'b000} +: 8] = rx_data_i;
          if (r_ff.bi == r_ff.last) begin
            nxt_r.bi = 2'h0;
            if (opc == pde_pkg::OPC_READ_DIRECT) begin
              nxt_r.bus_req = 1'b1;
              nxt_r.bus_we = 1'b0;
              nxt_r.bus_addr = nxt_r.addr;
              nxt_r.bus_size = size_b;
              nxt_r.st = pde_pkg::ST_BUS;
            end else if (opc == pde_pkg::OPC_WRITE_DIRECT) begin
              nxt_r.data = {24'h0, pde_pkg::ACK_CHAR};
              nxt_r.last = 2'h0;
              resp = 1'b1;
            end else begin
              nxt_r.ptr = nxt_r.addr;
              nxt_r.data = {24'h0, pde_pkg::ACK_CHAR};
              nxt_r.last = 2'h0;
              resp = 1'b1;
            end
          end else begin
            nxt_r.bi = r_ff.bi + 2'h1;
          end
        end
      end
      pde_pkg::ST_DATA: begin
        if (rx_valid_i) begin
          nxt_r.data[{r_ff.bi, 3'b000} +: 8] = rx_data_i;
          if (r_ff.bi == r_ff.last) begin
            nxt_r.bi = 2'h0;
            if (opc == pde_pkg::OPC_WRITE_CONTROL_REG) begin
              nxt_r.cs_we = 1'b1;
              nxt_r.cs_wdata = rx_data_i;
              done = 1'b1;
            end else begin
              nxt_r.bus_req = 1'b1;
              nxt_r.bus_we = 1'b1;
              nxt_r.bus_addr = (opc == pde_pkg::OPC_WRITE_DIRECT) ? r_ff.addr : r_ff.ptr;
              nxt_r.bus_wdata = nxt_r.data;
              nxt_r.bus_size = size_b;
              nxt_r.st = pde_pkg::ST_BUS;
            end
          end else begin
            nxt_r.bi = r_ff.bi + 2'h1;
          end
        end
      end
      pde_pkg::ST_CSRD: begin
        nxt_r.data = {24'h0, cs_rdata_i};
        nxt_r.last = 2'h0;
        resp = 1'b1;
      end
      pde_pkg::ST_BUS: begin
        // bus answer is waited on without limit; a hung bus needs a break
        if (bus_err_i) begin
          nxt_r.bus_req = 1'b0;
          nxt_r.st = pde_pkg::ST_ERR;
        end else if (bus_ack_i) begin
          nxt_r.bus_req = 1'b0;
          if (r_ff.bus_we) begin
            if (opc == pde_pkg::OPC_WRITE_VIA_POINTER && size_a == pde_pkg::PTR_AT_INC) begin
              nxt_r.ptr = r_ff.ptr + inc;
            end
            nxt_r.data = {24'h0, pde_pkg::ACK_CHAR};
            nxt_r.last = 2'h0;
          end else begin
            if (opc == pde_pkg::OPC_READ_VIA_POINTER && size_a == pde_pkg::PTR_AT_INC) begin
              nxt_r.ptr = r_ff.ptr + inc;
            end
            nxt_r.data = bus_rdata_i;
            nxt_r.last = size_b;
          end
          resp = 1'b1;
        end
      end
      pde_pkg::ST_GUARD: begin
        if (r_ff.gbits == guard_bits_i) begin
          nxt_r.st = pde_pkg::ST_TX;
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = r_ff.data[7:0];
          nxt_r.bi = 2'h0;
        end else if (r_ff.gcyc >= bit_period_i - 16'h1) begin
          nxt_r.gcyc = 16'h0;
          nxt_r.gbits = r_ff.gbits + 8'h1;
        end else begin
          nxt_r.gcyc = r_ff.gcyc + 16'h1;
        end
      end
      pde_pkg::ST_TX: begin
        if (r_ff.tx_valid && tx_ready_i) begin
          if (r_ff.bi == r_ff.last) begin
            nxt_r.tx_valid = 1'b0;
            nxt_r.turn = 1'b0;
            nxt_r.bi = 2'h0;
            if (opc == pde_pkg::OPC_WRITE_DIRECT && !r_ff.wr_phase) begin
              nxt_r.wr_phase = 1'b1;
              nxt_r.last = size_b;
              nxt_r.data = 32'h0;
              nxt_r.st = pde_pkg::ST_DATA;
            end else begin
              done = 1'b1;
            end
          end else begin
            nxt_r.bi = r_ff.bi + 2'h1;
            nxt_r.tx_data = r_ff.data[{r_ff.bi + 2'h1, 3'b000} +: 8];
          end
        end
      end
      pde_pkg::ST_ERR: begin
        nxt_r.err = 1'b1;
      end
      default: begin
        nxt_r.st = pde_pkg::ST_ERR;
      end
    endcase

    // ----------------------------------------------------------------
    // end of one execution; repeat without framing
    // ----------------------------------------------------------------
    if (done) begin
      if (r_ff.rpt_act && r_ff.rpt != 8'h0) begin
        nxt_r.rpt = r_ff.rpt - 8'h1;
        start = 1'b1;
      end else begin
        nxt_r.rpt_act = 1'b0;
        nxt_r.st = pde_pkg::ST_SYNC;
      end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    if (start) begin
      nopc = nxt_r.op[pde_pkg::OPC_MSB:pde_pkg::OPC_LSB];
      na = nxt_r.op[pde_pkg::SIZE_A_MSB:pde_pkg::SIZE_A_LSB];
      nb = nxt_r.op[pde_pkg::SIZE_B_MSB:pde_pkg::SIZE_B_LSB];
      nxt_r.bi = 2'h0;
      nxt_r.wr_phase = 1'b0;
      nxt_r.addr = 32'h0;
      nxt_r.data = 32'h0;
      case (nopc)
        pde_pkg::OPC_READ_DIRECT, pde_pkg::OPC_WRITE_DIRECT: begin
          if (na == pde_pkg::ASIZE_RESERVED) begin
            nxt_r.st = pde_pkg::ST_ERR;
          end else begin
            nxt_r.last = na;
            nxt_r.st = pde_pkg::ST_ADDR;
          end
        end
        pde_pkg::OPC_READ_VIA_POINTER: begin
          if (na == pde_pkg::PTR_REG) begin
            nxt_r.data = r_ff.ptr;
            nxt_r.last = nb;
            resp = 1'b1;
          end else if (na == pde_pkg::PTR_AT || na == pde_pkg::PTR_AT_INC) begin
            nxt_r.bus_req = 1'b1;
            nxt_r.bus_we = 1'b0;
            nxt_r.bus_addr = nxt_r.ptr;
            nxt_r.bus_size = nb;
            nxt_r.st = pde_pkg::ST_BUS;
          end else begin
            nxt_r.st = pde_pkg::ST_ERR;
          end
        end
        pde_pkg::OPC_WRITE_VIA_POINTER: begin
          if (na == pde_pkg::PTR_REG && nb != pde_pkg::ASIZE_RESERVED) begin
            nxt_r.last = nb;
            nxt_r.st = pde_pkg::ST_ADDR;
          end else if (na == pde_pkg::PTR_AT || na == pde_pkg::PTR_AT_INC) begin
            nxt_r.last = nb;
            nxt_r.st = pde_pkg::ST_DATA;
          end else begin
            nxt_r.st = pde_pkg::ST_ERR;
          end
        end
        pde_pkg::OPC_READ_CONTROL_REG: begin
          nxt_r.cs_addr = nxt_r.op[pde_pkg::CS_ADDR_MSB:pde_pkg::CS_ADDR_LSB];
          nxt_r.st = pde_pkg::ST_CSRD;
        end
        pde_pkg::OPC_WRITE_CONTROL_REG: begin
          nxt_r.cs_addr = nxt_r.op[pde_pkg::CS_ADDR_MSB:pde_pkg::CS_ADDR_LSB];
          nxt_r.last = 2'h0;
          nxt_r.st = pde_pkg::ST_DATA;
        end
        pde_pkg::OPC_LOOP_COUNT: begin
          nxt_r.last = nb;
          nxt_r.rpt = pde_pkg::RPT_RESET;
          nxt_r.st = pde_pkg::ST_RPT;
        end
        default: begin
          // key and unknown instructions are not served here
          nxt_r.st = pde_pkg::ST_ERR;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // answer: guard after a turnaround, else straight out
    // ----------------------------------------------------------------
    if (resp) begin
      nxt_r.bi = 2'h0;
      nxt_r.gcyc = 16'h0;
      nxt_r.gbits = 8'h0;
      if (nxt_r.turn) begin
        nxt_r.st = pde_pkg::ST_GUARD;
      end else begin
        nxt_r.st = pde_pkg::ST_TX;
        nxt_r.tx_valid = 1'b1;
        nxt_r.tx_data = nxt_r.data[7:0];
      end
    end

    // ----------------------------------------------------------------
    // line errors and break
    // ----------------------------------------------------------------
    if (rx_error_i && r_ff.st != pde_pkg::ST_ERR) begin
      nxt_r.st = pde_pkg::ST_ERR;
      nxt_r.err = 1'b1;
      nxt_r.bus_req = 1'b0;
      nxt_r.tx_valid = 1'b0;
    end
    if (rx_break_i) begin
      nxt_r.st = pde_pkg::ST_SYNC;
      nxt_r.err = 1'b0;
      nxt_r.rpt = pde_pkg::RPT_RESET;
      nxt_r.rpt_act = 1'b0;
      nxt_r.rpt_pend = 1'b0;
      nxt_r.bus_req = 1'b0;
      nxt_r.tx_valid = 1'b0;
      nxt_r.cs_we = 1'b0;
      nxt_r.turn = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r_ff <= '0;
      r_ff.st <= pde_pkg::ST_SYNC;
      r_ff.ptr <= pde_pkg::PTR_RESET;
      r_ff.rpt <= pde_pkg::RPT_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tx_valid_o = r_ff.tx_valid;
  assign tx_data_o = r_ff.tx_data;
  assign bus_req_o = r_ff.bus_req;
  assign bus_we_o = r_ff.bus_we;
  assign bus_addr_o = r_ff.bus_addr;
  assign bus_wdata_o = r_ff.bus_wdata;
  assign bus_size_o = r_ff.bus_size;
  assign cs_we_o = r_ff.cs_we;
  assign cs_addr_o = r_ff.cs_addr;
  assign cs_wdata_o = r_ff.cs_wdata;
  assign pointer_o = r_ff.ptr;
  assign error_state_o = r_ff.err;

endmodule

// ### pde_mem_model.sv
`timescale 1ns/1ps
module pde_mem_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic bus_req_i,
  input wire logic bus_we_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic [1:0] bus_size_i,
  output logic bus_ack_o,
  output logic bus_err_o,
  output logic [31:0] bus_rdata_o
);
  // ----
  // byte memory; odd addresses answer slowly, 0xee faults
  // ----
  logic [7:0] mem [256];
  logic [7:0] a;
  logic [2:0] cnt_q;
  logic [2:0] lat;
  logic done_q;
  assign a = bus_addr_i[7:0];
  assign lat = a[0] ? 3'h4 : 3'h0;
  initial begin
    bus_ack_o = 1'b0;
    bus_err_o = 1'b0;
    bus_rdata_o = 32'h0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  always @(posedge clk_i) begin
    bus_ack_o <= 1'b0;
    bus_err_o <= 1'b0;
    // stale read data flips so it never passes for an answer
    bus_rdata_o <= ~bus_rdata_o;
    if (!resetn_i || !bus_req_i) begin
      cnt_q <= 3'h0;
      done_q <= 1'b0;
    end else if (!done_q && cnt_q != lat) begin
      cnt_q <= cnt_q + 3'h1;
    end else if (!done_q) begin
      done_q <= 1'b1;
      bus_err_o <= (a == 8'hee);
      bus_ack_o <= (a != 8'hee);
      bus_rdata_o <= {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]};
      if (bus_we_i && a != 8'hee) begin
        for (int i = 0; i <= int'(bus_size_i); i++) mem[a + 8'(i)] <= bus_wdata_i[8*i +: 8];
      end
    end
  end
endmodule

// ### pde_engine_chk.sv
`timescale 1ns/1ps
module pde_engine_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic rx_valid_i,
  input wire logic rx_break_i,
  input wire logic rx_error_i,
  input wire logic [15:0] bit_period_i,
  input wire logic [7:0] guard_bits_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic bus_req_o,
  input wire logic bus_we_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic bus_ack_i,
  input wire logic bus_err_i,
  input wire logic cs_we_o,
  input wire logic error_state_o
);
  // ----
  // cycles since the last received byte, saturating
  // ----
  logic [15:0] quiet_ff;
  logic [15:0] nxt_quiet;
  assign nxt_quiet = rx_valid_i ? 16'h0 : quiet_ff + {15'h0, quiet_ff != 16'hffff};
  always_ff @(posedge clk_i) quiet_ff <= resetn_i ? nxt_quiet : 16'h0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_write_ok;
    bus_req_o && bus_we_o && bus_ack_i;
  endsequence
  sequence s_ack_sent;
    ##[1:60] (tx_valid_o && tx_data_o == pde_pkg::ACK_CHAR);
  endsequence
  property p_write_ack;
    s_write_ok |-> s_ack_sent;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("no ack after bus write");
  property p_req_hold;
    bus_req_o && !bus_ack_i && !bus_err_i && !rx_break_i && !rx_error_i
      |=> bus_req_o && $stable(bus_addr_o) && $stable(bus_we_o);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request dropped early");
  property p_req_drop;
    bus_req_o && (bus_ack_i || bus_err_i) |=> !bus_req_o;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("bus request held after end");
  property p_tx_hold;
    tx_valid_o && !tx_ready_i && !rx_break_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte not held");
  property p_guard;
    $rose(tx_valid_o) |-> 32'(quiet_ff) >= 32'(guard_bits_i) * 32'(bit_period_i);
  endproperty
  a_guard: assert property (p_guard) else $error("answer before guard time");
  property p_cs_quiet;
    cs_we_o |=> (!cs_we_o && !tx_valid_o) [*4];
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("control write answered");
  property p_err_stay;
    error_state_o && !rx_break_i |=> error_state_o;
  endproperty
  a_err_stay: assert property (p_err_stay) else $error("error left without break");
  property p_err_quiet;
    error_state_o && $past(error_state_o) |-> !bus_req_o && !cs_we_o;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("access in error state");
  property p_rx_err;
    rx_error_i && !rx_break_i |-> ##[1:3] error_state_o;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("line error not trapped");
  property p_break;
    rx_break_i |-> ##[1:2] (!error_state_o && !tx_valid_o && !bus_req_o);
  endproperty
  a_break: assert property (p_break) else $error("break did not abort");
endmodule

bind pde_engine pde_engine_chk u_chk (.*);

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  // ----
  // stimulus, design and far-side memory
  // ----
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h0;
  logic rx_break_i = 1'b0;
  logic rx_error_i = 1'b0;
  logic tx_ready_i = 1'b0;
  // short bit period keeps the guard to a few cycles
  logic [15:0] bit_period_i = 16'h2;
  logic [7:0] guard_bits_i = 8'h2;
  logic tx_valid_o, bus_req_o, bus_we_o, bus_ack_i, bus_err_i, cs_we_o, error_state_o;
  logic [7:0] tx_data_o, cs_wdata_o, cs_rdata_i;
  logic [31:0] bus_addr_o, bus_wdata_o, bus_rdata_i, pointer_o;
  logic [1:0] bus_size_o;
  logic [3:0] cs_addr_o;
  logic [7:0] csr [16];
  logic [7:0] sq[$];
  int n_fail = 0;
  int n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  pde_engine dut (.*);
  pde_mem_model u_mem (.clk_i(clk_i), .resetn_i(resetn_i), .bus_req_i(bus_req_o),
    .bus_we_i(bus_we_o), .bus_addr_i(bus_addr_o), .bus_wdata_i(bus_wdata_o),
    .bus_size_i(bus_size_o), .bus_ack_o(bus_ack_i), .bus_err_o(bus_err_i),
    .bus_rdata_o(bus_rdata_i));
  assign cs_rdata_i = csr[cs_addr_o];
  initial begin
    for (int i = 0; i < 16; i++) csr[i] = 8'hc0 | 8'(i);
  end
  always @(posedge clk_i) begin
    if (cs_we_o === 1'b1) csr[cs_addr_o] <= cs_wdata_o;
  end
  task automatic test_done();
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    if (k == 300) begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic send();
    tick(1);
    foreach (sq[i]) begin
      rx_data_i = sq[i];
      rx_valid_i = 1'b1;
      tick(1);
    end
    rx_valid_i = 1'b0;
    sq.delete();
  endtask
  // the line side stalls one cycle on every byte
  task automatic get(input logic [7:0] exp);
    wait_hi(tx_valid_o);
    tick(1);
    `CHK(tx_data_o, exp)
    tx_ready_i = 1'b1;
    tick(1);
    tx_ready_i = 1'b0;
  endtask
  task automatic pulse_break();
    rx_break_i = 1'b1;
    tick(1);
    rx_break_i = 1'b0;
    tick(2);
  endtask
  task automatic err_case();
    send();
    wait_hi(error_state_o);
    sq = '{8'h55, 8'h83};
    send();
    tick(20);
    `CHK({tx_valid_o, bus_req_o, error_state_o}, 3'h1)
    pulse_break();
    `CHK(error_state_o, 1'b0)
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    tick(16);
    `CHK({tx_valid_o, bus_req_o, cs_we_o, error_state_o, pointer_o}, 36'h0)
    resetn_i = 1'b1;
    sq = '{8'h55, 8'hc3, 8'ha5};
    send();
    wait_hi(cs_we_o);
    `CHK({cs_addr_o, cs_wdata_o}, 12'h3a5)
    sq = '{8'h55, 8'h83};
    send();
    get(8'ha5);
    sq = '{8'h55, 8'h69, 8'h00, 8'h10};
    send();
    get(8'h40);
    `CHK(pointer_o, 32'h1000)
    sq = '{8'h55, 8'h64, 8'h77};
    send();
    get(8'h40);
    `CHK(pointer_o, 32'h1001)
    sq = '{8'h55, 8'h60, 8'h88};
    send();
    get(8'h40);
    `CHK(pointer_o, 32'h1001)
    sq = '{8'h55, 8'ha0, 8'h02, 8'h55, 8'h24};
    send();
    get(8'h88);
    get(8'h58);
    get(8'h59);
    `CHK(pointer_o, 32'h1004)
    sq = '{8'h55, 8'h2b};
    send();
    get(8'h04);
    get(8'h10);
    get(8'h00);
    get(8'h00);
    sq = '{8'h55, 8'ha0, 8'h01, 8'h55, 8'h00, 8'h30};
    send();
    get(8'h6a);
    sq = '{8'h10};
    send();
    get(8'h4a);
    sq = '{8'h55, 8'h45, 8'h40, 8'h00};
    send();
    get(8'h40);
    sq = '{8'hde, 8'had};
    send();
    get(8'h40);
    sq = '{8'h55, 8'h07, 8'h40, 8'h00};
    send();
    get(8'hde);
    get(8'had);
    get(8'h18);
    get(8'h19);
    sq = '{8'h55, 8'h08, 8'h41, 8'h00, 8'h00};
    send();
    get(8'had);
    sq = '{8'h55, 8'ha0, 8'h05, 8'h55, 8'h24};
    send();
    get(8'h5e);
    get(8'h5f);
    pulse_break();
    tick(30);
    `CHK(tx_valid_o, 1'b0)
    sq = '{8'h55, 8'h83};
    send();
    get(8'ha5);
    sq = '{8'h55, 8'h69, 8'h20, 8'h00};
    send();
    get(8'h40);
    sq = '{8'h55, 8'ha0, 8'h01, 8'h55, 8'h64, 8'h11};
    send();
    get(8'h40);
    sq = '{8'h22};
    send();
    get(8'h40);
    `CHK(pointer_o, 32'h22)
    sq = '{8'h55, 8'h01, 8'h20};
    send();
    get(8'h11);
    get(8'h22);
    sq = '{8'haa};
    err_case();
    sq = '{8'h55, 8'h0c};
    err_case();
    sq = '{8'h55, 8'ha0, 8'h00, 8'h55, 8'ha0};
    err_case();
    sq = '{8'h55, 8'he0};
    err_case();
    sq = '{8'h55, 8'h6b};
    err_case();
    sq = '{8'h55, 8'h00, 8'hee};
    err_case();
    rx_error_i = 1'b1;
    tick(1);
    rx_error_i = 1'b0;
    err_case();
    test_done();
  end
endmodule
